// file: asq_pkg.sv
// constants and types for the converter acquisition and conversion sequencer
// How it works
// - with acquisition time select at 000, go ends sampling at once and conversion starts.
// - with a nonzero acquisition select, go keeps sampling for that time, then converts.
// - during programmed acquisition the selected input stays sampled, so software need not wait.
// - at the end of a conversion go clears, the done flag sets and sampling resumes.
// - no register bit shows where acquisition ends and conversion begins (sample_o and convert_o do); go stays set through both.
// - a conversion lasts 11 bit periods at 10-bit resolution and 13 at 12-bit resolution.
// - the clock select picks 2, 4, 8, 16, 32, 64 or 128 oscillator periods or the internal RC source.
// - with the RC source chosen, bit periods come from the RC ticks, not the system clock.
// - channel select and direction bits never gate the start or end of a conversion.
// - port data reads return zero on every pin configured as analog.
package asq_pkg;
  localparam int DW = 8;
  localparam int AW = 4;
  localparam int NPIN = 16;
  localparam int RW = 12;
  // register offsets
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_MASK = 4'h3;
  localparam logic [3:0] OFS_ANCFG_LO = 4'h4;
  localparam logic [3:0] OFS_ANCFG_HI = 4'h5;
  localparam logic [3:0] OFS_DIR_LO = 4'h6;
  localparam logic [3:0] OFS_DIR_HI = 4'h7;
  localparam logic [3:0] OFS_PORT_LO = 4'h8;
  localparam logic [3:0] OFS_PORT_HI = 4'h9;
  localparam logic [3:0] OFS_RES_LO = 4'hA;
  localparam logic [3:0] OFS_RES_HI = 4'hB;
  // field positions
  localparam int GO_BIT = 0;
  localparam int CHS_LSB = 1;
  localparam int CHS_W = 4;
  localparam int ADCS_LSB = 0;
  localparam int ACQT_LSB = 3;
  localparam int SEL_W = 3;
  localparam int RES12_BIT = 7;
  localparam int DONE_BIT = 0;
  // reset values and select codes
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [15:0] ANCFG_RST = 16'h0000;
  localparam logic [15:0] DIR_RST = 16'hFFFF;
  localparam logic [2:0] ACQT_NONE = 3'h0;
  localparam logic [2:0] ADCS_RC = 3'h3;
  // timing counts in bit periods, divider width and states
  localparam logic [4:0] CONV_TAD_10 = 5'd11;
  localparam logic [4:0] CONV_TAD_12 = 5'd13;
  localparam int DIV_W = 7;
  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_ACQ,
    ST_CONV
  } asq_state_e;
endpackage

// file: asq_tad_gen.sv
// bit period tick generator: divided oscillator or internal rc ticks
`timescale 1ns/1ns
module asq_tad_gen (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // control
  input wire logic run_i,
  input wire logic [asq_pkg::SEL_W-1:0] sel_i,
  input wire logic rc_tick_i,
  // tick out
  output logic tick_o
);
  import asq_pkg::*;
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } asq_tad_s;
  asq_tad_s s_q;
  asq_tad_s s_d;
  logic [2:0] idx;
  logic [DIV_W-1:0] period;
  always_comb begin
    idx = {sel_i[1:0], sel_i[2]};
    // 000:2 100:4 001:8 101:16 010:32 110:64
    period = DIV_W'(2) << idx;
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run_i) begin
      s_d.cnt = '0;
    end else if (sel_i == ADCS_RC) begin
      s_d.tick = rc_tick_i;
      s_d.cnt = '0;
    end else if (s_q.cnt == period - DIV_W'(1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + DIV_W'(1);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_o = s_q.tick;
endmodule

// file: asq_sequencer.sv
// converter acquisition and conversion sequencer with register port
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module asq_sequencer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [asq_pkg::AW-1:0] addr_i,
  input wire logic [asq_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [asq_pkg::DW-1:0] rdata_o,
  // interrupt
  output logic irq_o,
  // pins and rc source
  input wire logic [asq_pkg::NPIN-1:0] pin_i,
  input wire logic rc_tick_i,
  // converter array
  input wire logic [asq_pkg::RW-1:0] result_i,
  output logic sample_o,
  output logic convert_o,
  output logic res12_o,
  output logic tad_tick_o,
  output logic [asq_pkg::CHS_W-1:0] channel_o,
  output logic [asq_pkg::NPIN-1:0] analog_en_o
);
  import asq_pkg::*;

  typedef struct packed {
    asq_state_e st;
    logic go;
    logic [CHS_W-1:0] chs;
    logic [DW-1:0] ctrl1;
    logic done_flag;
    logic done_mask;
    logic [NPIN-1:0] ancfg;
    logic [NPIN-1:0] dir;
    logic [RW-1:0] result;
    logic [SEL_W-1:0] acqt_l;
    logic [SEL_W-1:0] adcs_l;
    logic res12_l;
    logic [4:0] tad_cnt;
    logic [DW-1:0] rdata;
    logic irq;
    logic sample;
    logic convert;
    logic tad_tick;
  } asq_seq_s;

  asq_seq_s s_q;
  asq_seq_s s_d;
  logic tick;
  logic run;
  logic [NPIN-1:0] port_rd;
  logic wr_ctrl0;
  logic go_req;
  logic last_tad;
  logic [4:0] acq_len;
  logic [4:0] conv_len;

  // port data read per pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_port
      assign port_rd[gi] = s_q.ancfg[gi] ? 1'b0 : pin_i[gi];
    end
  endgenerate

  assign run = (s_q.st != ST_SAMPLE);

  asq_tad_gen u_tad (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .run_i(run),
    .sel_i(s_q.adcs_l),
    .rc_tick_i(rc_tick_i),
    .tick_o(tick)
  );

  always_comb begin
    wr_ctrl0 = wr_i && (addr_i == OFS_CTRL0);
    go_req = wr_ctrl0 && wdata_i[GO_BIT] && !s_q.go;
    acq_len = {1'b0, s_q.acqt_l, 1'b0};
    conv_len = s_q.res12_l ? CONV_TAD_12 : CONV_TAD_10;
    last_tad = 1'b0;
    s_d = s_q;
    s_d.tad_tick = tick;

    // register writes
    if (wr_i) begin
      case (addr_i)
        OFS_CTRL0: begin
          s_d.chs = wdata_i[CHS_LSB +: CHS_W];
        end
        OFS_CTRL1: begin
          s_d.ctrl1 = wdata_i;
        end
        OFS_STATUS: begin
          if (wdata_i[DONE_BIT]) begin
            s_d.done_flag = 1'b0;
          end
        end
        OFS_MASK: begin
          s_d.done_mask = wdata_i[DONE_BIT];
        end
        OFS_ANCFG_LO: begin
          s_d.ancfg[7:0] = wdata_i;
        end
        OFS_ANCFG_HI: begin
          s_d.ancfg[15:8] = wdata_i;
        end
        OFS_DIR_LO: begin
          s_d.dir[7:0] = wdata_i;
        end
        OFS_DIR_HI: begin
          s_d.dir[15:8] = wdata_i;
        end
        default: begin
          s_d.ctrl1 = s_q.ctrl1;
        end
      endcase
    end

    // sequencer; channel and direction bits never gate it
    case (s_q.st)
      ST_SAMPLE: begin
        s_d.sample = 1'b1;
        s_d.convert = 1'b0;
        s_d.tad_cnt = '0;
        if (go_req) begin
          s_d.go = 1'b1;
          s_d.acqt_l = s_d.ctrl1[ACQT_LSB +: SEL_W];
          s_d.adcs_l = s_d.ctrl1[ADCS_LSB +: SEL_W];
          s_d.res12_l = s_d.ctrl1[RES12_BIT];
          if (s_d.ctrl1[ACQT_LSB +: SEL_W] == ACQT_NONE) begin
            s_d.st = ST_CONV;
            s_d.sample = 1'b0;
            s_d.convert = 1'b1;
          end else begin
            s_d.st = ST_ACQ;
            s_d.sample = 1'b1;
          end
        end
      end
      ST_ACQ: begin
        s_d.sample = 1'b1;
        s_d.convert = 1'b0;
        if (tick) begin
          if (s_q.tad_cnt == acq_len - 5'd1) begin
            s_d.tad_cnt = '0;
            s_d.st = ST_CONV;
            s_d.sample = 1'b0;
            s_d.convert = 1'b1;
          end else begin
            s_d.tad_cnt = s_q.tad_cnt + 5'd1;
          end
        end
      end
      ST_CONV: begin
        s_d.sample = 1'b0;
        s_d.convert = 1'b1;
        if (tick) begin
          if (s_q.tad_cnt == conv_len - 5'd1) begin
            last_tad = 1'b1;
            s_d.tad_cnt = '0;
          end else begin
            s_d.tad_cnt = s_q.tad_cnt + 5'd1;
          end
        end
      end
      default: begin
        s_d.st = ST_SAMPLE;
      end
    endcase

    // completion; the set wins over a same cycle clear
    if (last_tad) begin
      s_d.st = ST_SAMPLE;
      s_d.go = 1'b0;
      s_d.done_flag = 1'b1;
      s_d.sample = 1'b1;
      s_d.convert = 1'b0;
      s_d.result = result_i;
    end

    s_d.irq = s_d.done_flag && s_d.done_mask;

    // read data, one cycle after the strobe
    s_d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_CTRL0: begin
          // go stays high through acquisition and conversion alike
          s_d.rdata = {3'h0, s_q.chs, s_q.go};
        end
        OFS_CTRL1: begin
          s_d.rdata = s_q.ctrl1;
        end
        OFS_STATUS: begin
          s_d.rdata = {7'h00, s_q.done_flag};
        end
        OFS_MASK: begin
          s_d.rdata = {7'h00, s_q.done_mask};
        end
        OFS_ANCFG_LO: begin
          s_d.rdata = s_q.ancfg[7:0];
        end
        OFS_ANCFG_HI: begin
          s_d.rdata = s_q.ancfg[15:8];
        end
        OFS_DIR_LO: begin
          s_d.rdata = s_q.dir[7:0];
        end
        OFS_DIR_HI: begin
          s_d.rdata = s_q.dir[15:8];
        end
        OFS_PORT_LO: begin
          s_d.rdata = port_rd[7:0];
        end
        OFS_PORT_HI: begin
          s_d.rdata = port_rd[15:8];
        end
        OFS_RES_LO: begin
          s_d.rdata = s_q.result[7:0];
        end
        OFS_RES_HI: begin
          s_d.rdata = {4'h0, s_q.result[11:8]};
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_q <= '0;
      s_q.st <= ST_SAMPLE;
      s_q.ctrl1 <= CTRL1_RST;
      s_q.ancfg <= ANCFG_RST;
      s_q.dir <= DIR_RST;
      s_q.sample <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign irq_o = s_q.irq;
  assign sample_o = s_q.sample;
  assign convert_o = s_q.convert;
  assign res12_o = s_q.res12_l;
  assign tad_tick_o = s_q.tad_tick;
  assign channel_o = s_q.chs;
  assign analog_en_o = s_q.ancfg;
endmodule

// file: asq_seq_sva.sv
// port assertions for the acquisition and conversion sequencer
`timescale 1ns/1ns
module asq_seq_sva (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [asq_pkg::AW-1:0] addr_i,
  input wire logic [asq_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [asq_pkg::DW-1:0] rdata_o,
  // converter side
  input wire logic irq_o,
  input wire logic sample_o,
  input wire logic convert_o,
  input wire logic res12_o,
  input wire logic tad_tick_o,
  input wire logic [asq_pkg::NPIN-1:0] analog_en_o
);
  import asq_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic go_st;
  logic busy_q, prev_q, mask_q;
  logic [2:0] acq_q;
  logic [4:0] cnt_q;
  assign go_st = wr_i && addr_i == OFS_CTRL0 && wdata_i[GO_BIT] && !busy_q;
  // tracks a started conversion and counts bit ticks while converting
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      busy_q <= 1'b0;
      prev_q <= 1'b0;
      mask_q <= 1'b0;
      acq_q <= 3'h0;
      cnt_q <= 5'h00;
    end else begin
      prev_q <= convert_o;
      if (go_st) busy_q <= 1'b1;
      else if (prev_q && !convert_o) busy_q <= 1'b0;
      if (wr_i && addr_i == OFS_CTRL1) acq_q <= wdata_i[ACQT_LSB+:SEL_W];
      if (wr_i && addr_i == OFS_MASK) mask_q <= wdata_i[DONE_BIT];
      if (!convert_o && !prev_q) cnt_q <= 5'h00;
      else if (prev_q && tad_tick_o) cnt_q <= cnt_q + 5'h01;
    end
  end
  a_conv_no_sample: assert property (convert_o |-> !sample_o)
    else $error("sampling while converting");
  a_go_now: assert property (go_st && acq_q == 3'h0 |=> convert_o && !sample_o)
    else $error("no immediate conversion");
  a_acq_first: assert property (go_st && acq_q != 3'h0 |=> sample_o && !convert_o)
    else $error("acquisition skipped");
  a_done_back: assert property ($fell(convert_o) |-> sample_o && irq_o == mask_q)
    else $error("completion wrong");
  a_tad_count: assert property ($fell(convert_o)
    |-> cnt_q + 5'(tad_tick_o) == (res12_o ? CONV_TAD_12 : CONV_TAD_10))
    else $error("bit period count wrong");
  a_go_reads: assert property (rd_i && addr_i == OFS_CTRL0
    && (convert_o || busy_q && !prev_q) |=> rdata_o[GO_BIT])
    else $error("go not set while busy");
  a_res_hold: assert property (convert_o && prev_q |-> $stable(res12_o))
    else $error("resolution changed mid conversion");
  a_port_zero: assert property (rd_i && addr_i == OFS_PORT_LO
    |=> (rdata_o & analog_en_o[7:0]) == 8'h00)
    else $error("analog pin read nonzero");
  a_irq_clear: assert property (wr_i && addr_i == OFS_STATUS && wdata_i[DONE_BIT]
    && !convert_o && !prev_q |=> !irq_o)
    else $error("irq not cleared");
  c_acq: cover property (go_st && acq_q != 3'h0);
  c_done12: cover property ($fell(convert_o) && res12_o);
  c_irq: cover property ($rose(irq_o));
endmodule

// file: asq_front_model.sv
// analog front end stand-in: free running rc ticks and one result per conversion
`timescale 1ns/1ns
module asq_front_model #(
  parameter int RC_DIV = 6
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // converter side
  input wire logic convert_i,
  output logic rc_tick_o,
  output logic [asq_pkg::RW-1:0] result_o
);
  int div_q = 0;
  logic conv_q = 1'b0;
  logic [11:0] val_q = 12'h59F;
  always_ff @(posedge clk_sys_i) begin
    conv_q <= convert_i;
    div_q <= (div_q >= RC_DIV - 1) ? 0 : div_q + 1;
    if (srst_i) val_q <= 12'h59F;
    else if (convert_i && !conv_q) val_q <= val_q + 12'h001;
  end
  assign rc_tick_o = (div_q == RC_DIV - 1);
  // result only meaningful while converting
  assign result_o = convert_i ? val_q : ~val_q;
endmodule

// file: adc_acquisition_and_conversion_sequencer_tb_top.sv
// self-checking bench for the acquisition and conversion sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module adc_acquisition_and_conversion_sequencer_tb_top;
  import asq_pkg::*;
  typedef struct {logic [7:0] cfg; int t; logic msk; logic dis;} asq_row_s;
  localparam int RC_DIV = 6;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rc_tick_i;
  logic irq_o, sample_o, convert_o, res12_o, tad_tick_o, seen;
  logic [3:0] addr_i = 4'h0, channel_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, d;
  logic [15:0] pin_i = 16'hFFFF, analog_en_o;
  logic [11:0] result_i;
  int err_count = 0, samples_checked = 0, n, e;
  asq_row_s rows [7] = '{'{8'h00, 2, 1, 0}, '{8'h8C, 4, 1, 0}, '{8'h11, 8, 0, 0},
    '{8'h85, 16, 1, 1}, '{8'h02, 32, 1, 0}, '{8'h06, 64, 1, 0}, '{8'h9B, RC_DIV, 1, 0}};
  logic [3:0] ra [5] = '{OFS_CTRL0, OFS_CTRL1, OFS_STATUS, OFS_DIR_LO, 4'hF};
  logic [7:0] re [5] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  asq_sequencer uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .pin_i(pin_i), .rc_tick_i(rc_tick_i), .result_i(result_i), .sample_o(sample_o),
    .convert_o(convert_o), .res12_o(res12_o), .tad_tick_o(tad_tick_o),
    .channel_o(channel_o), .analog_en_o(analog_en_o));
  asq_front_model #(.RC_DIV(RC_DIV)) afe (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .convert_i(convert_o), .rc_tick_o(rc_tick_i), .result_o(result_i));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    wr(OFS_DIR_LO, 8'h00);
    wr(OFS_DIR_HI, 8'hFF);
    wr(OFS_ANCFG_LO, 8'h0F);
    rd(OFS_PORT_LO, d);
    `CHK("port", 8'hF0, d)
    `CHK("analog enable", 16'h000F, analog_en_o)
    foreach (rows[i]) begin
      wr(OFS_MASK, {7'h00, rows[i].msk});
      wr(OFS_CTRL1, rows[i].cfg);
      wr(OFS_CTRL0, 8'h1F);
      n = 0;
      seen = 1'b0;
      if (rows[i].dis) wr(OFS_CTRL1, 8'h00);
      rd(OFS_CTRL0, d);
      `CHK("go busy", 8'h1F, d)
      `CHK("channel", 4'hF, channel_o)
      while (n < 3000 && !(seen && !convert_o)) begin
        @(posedge clk_sys_i);
        #1;
        seen |= convert_o;
        n++;
      end
      e = (2 * rows[i].cfg[5:3] + (rows[i].cfg[7] ? 13 : 11)) * rows[i].t;
      `CHK("elapsed", 1'b1, (n >= e - rows[i].t - 3 && n <= e + rows[i].t + 3))
      rd(OFS_CTRL0, d);
      `CHK("go", 1'b0, d[GO_BIT])
      rd(OFS_STATUS, d);
      `CHK("done", 8'h01, d)
      `CHK("irq", rows[i].msk, irq_o)
      rd(OFS_RES_LO, d);
      `CHK("result", 8'(12'h5A0 + i), d)
      wr(OFS_STATUS, 8'h01);
      #1;
      `CHK("irq clear", 1'b0, irq_o)
    end
    wr(OFS_CTRL1, 8'h06);
    wr(OFS_CTRL0, 8'h01);
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    `CHK("idle", 2'b10, {sample_o, convert_o})
    foreach (ra[i]) begin
      rd(ra[i], d);
      `CHK("reset read", re[i], d)
    end
    rd(OFS_PORT_LO, d);
    `CHK("digital port", 8'hFF, d)
    tally_and_finish();
  end
endmodule
bind asq_sequencer asq_seq_sva chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .sample_o(sample_o), .convert_o(convert_o), .res12_o(res12_o),
  .tad_tick_o(tad_tick_o), .analog_en_o(analog_en_o));
